//--- logic/seif_front.sv
// Purpose: Slave-side two-wire bus front end of a serial EEPROM
// Assumes: Bus clock and data arrive unsynchronised; memory side runs on clock
// Notes: Accepted write bytes leave through a small buffer; prog_start commits them
`timescale 1ns/10ps

module seif_front #(
	parameter logic [3:0] TYPE_ID = 4'h5, // Arbitrary value, set per product
	parameter int BUF_DEPTH = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic select_strap_low_bit,
	input wire logic select_strap_high_bit,
	input wire logic write_inhibit_in,
	output logic [seif_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [seif_pkg::BYTE_W-1:0] mem_rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output seif_pkg::seif_wr_word_t wr_word,
	output logic prog_start,
	input wire logic prog_busy
);
	import seif_pkg::*;

	localparam int PTR_W = $clog2(BUF_DEPTH);

	if (BUF_DEPTH < 2 || (1 << PTR_W) != BUF_DEPTH)
	begin
		$error("BUF_DEPTH must be a power of two, at least 2");
	end

	function automatic logic sel_match(input logic [BYTE_W-1:0] sel, input logic hi,
		input logic lo);
		sel_match = sel[SEL_ID_MSB:SEL_ID_LSB] == TYPE_ID && sel[SEL_STRAP_HI] == hi
			&& sel[SEL_STRAP_LO] == lo;
	endfunction

	logic [PIN_COUNT-1:0] pin_meta_q;
	logic [PIN_COUNT-1:0] pin_s_q;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	seif_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [BYTE_W-1:0] shift_q;
	logic [BYTE_W-1:0] tx_q;
	logic ninth_q;
	logic after_ack_q;
	logic wr_pending_q;
	logic wp_q;
	logic drive_low_q;
	logic [ADDR_W-1:0] addr_q;
	logic [BYTE_W-1:0] addr_hi_q;
	logic top_addr_q;
	logic prog_start_q;
	logic push;
	logic buf_full;
	logic buf_empty;
	seif_wr_word_t buf_q [BUF_DEPTH];
	logic [PTR_W:0] wr_ptr_q;
	logic [PTR_W:0] rd_ptr_q;

	// ----------------------------------------
	// Pin sampling and bus conditions
	// ----------------------------------------

	// Unconnected straps and inhibit settle low through reset value
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_q <= PIN_RESET;
			pin_s_q <= PIN_RESET;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			pin_meta_q <= {scl_in, sda_in, select_strap_high_bit, select_strap_low_bit,
				write_inhibit_in};
			pin_s_q <= pin_meta_q;
			scl_p_q <= pin_s_q[PIN_SCL];
			sda_p_q <= pin_s_q[PIN_SDA];
		end
	end

	assign scl_s = pin_s_q[PIN_SCL];
	assign sda_s = pin_s_q[PIN_SDA];
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	// Starts are not seen at all while programming
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s && !prog_busy;
	assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

	// ----------------------------------------
	// Receive shifter
	// ----------------------------------------

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			shift_q <= '0;
		else if (scl_rise && state_q != S_IDLE && bit_cnt_q < ACK_SLOT)
			shift_q <= {shift_q[BYTE_W-2:0], sda_s};
	end

	// ----------------------------------------
	// Protocol sequencer
	// ----------------------------------------

	// Slave only: nothing here ever drives the clock or opens a transfer
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_q <= S_IDLE;
			bit_cnt_q <= CNT_RESET;
			ninth_q <= 1'b0;
			after_ack_q <= 1'b0;
			wr_pending_q <= 1'b0;
			wp_q <= 1'b0;
			drive_low_q <= 1'b0;
			addr_q <= ADDR_RESET;
			addr_hi_q <= '0;
			top_addr_q <= 1'b0;
			tx_q <= '0;
		end
		else if (prog_busy)
		begin
			state_q <= S_IDLE;
			drive_low_q <= 1'b0;
			bit_cnt_q <= CNT_RESET;
			ninth_q <= 1'b0;
			after_ack_q <= 1'b0;
			wr_pending_q <= 1'b0;
		end
		else if (start_det)
		begin
			state_q <= S_SELECT;
			bit_cnt_q <= CNT_RESET;
			ninth_q <= 1'b0;
			after_ack_q <= 1'b0;
			drive_low_q <= 1'b0;
			wr_pending_q <= 1'b0;
			wp_q <= 1'b0;
		end
		else if (stop_det)
		begin
			state_q <= S_IDLE;
			bit_cnt_q <= CNT_RESET;
			ninth_q <= 1'b0;
			after_ack_q <= 1'b0;
			drive_low_q <= 1'b0;
			wr_pending_q <= 1'b0;
		end
		else if (state_q == S_IDLE)
		begin
			drive_low_q <= 1'b0;
		end
		else if (scl_rise)
		begin
			// Inhibit counts from start to end of the address bytes
			if (state_q != S_WDATA && state_q != S_RDATA)
				wp_q <= wp_q | pin_s_q[PIN_WINHIBIT];
			if (bit_cnt_q == ACK_SLOT)
			begin
				bit_cnt_q <= CNT_RESET;
				ninth_q <= 1'b1;
				after_ack_q <= 1'b1;
				if (state_q == S_RDATA && sda_s)
					state_q <= S_IDLE;
			end
			else
				bit_cnt_q <= bit_cnt_q + 4'h1;
		end
		else if (scl_fall)
		begin
			if (bit_cnt_q == 4'h1)
				after_ack_q <= 1'b0;
			if (ninth_q)
			begin
				ninth_q <= 1'b0;
				drive_low_q <= 1'b0;
				if (state_q == S_RDATA)
				begin
					tx_q <= mem_rd_data;
					drive_low_q <= !mem_rd_data[BYTE_W-1];
					addr_q <= addr_q + 17'h0_0001;
				end
			end
			else if (bit_cnt_q == ACK_SLOT)
			begin
				drive_low_q <= 1'b0;
				case (state_q)
					S_SELECT:
					begin
						if (sel_match(shift_q, pin_s_q[PIN_STRAP_HI],
							pin_s_q[PIN_STRAP_LO]))
						begin
							drive_low_q <= 1'b1;
							top_addr_q <= shift_q[SEL_TOP_ADDR];
							state_q <= shift_q[SEL_RW] ? S_RDATA : S_ADDR_HI;
						end
						else
							state_q <= S_IDLE;
					end
					S_ADDR_HI:
					begin
						drive_low_q <= 1'b1;
						addr_hi_q <= shift_q;
						state_q <= S_ADDR_LO;
					end
					S_ADDR_LO:
					begin
						drive_low_q <= 1'b1;
						addr_q <= {top_addr_q, addr_hi_q, shift_q};
						state_q <= S_WDATA;
					end
					S_WDATA:
					begin
						// Full buffer refuses the byte rather than lose it
						if (!wp_q && !buf_full)
						begin
							drive_low_q <= 1'b1;
							wr_pending_q <= 1'b1;
							addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 8'h01;
						end
					end
					S_RDATA:
						drive_low_q <= 1'b0;
					default:
						state_q <= S_IDLE;
				endcase
			end
			else if (state_q == S_RDATA && bit_cnt_q < ACK_SLOT)
				drive_low_q <= !tx_q[3'(BYTE_W - 1) - bit_cnt_q[2:0]];
		end
	end

	assign push = scl_fall && !ninth_q && bit_cnt_q == ACK_SLOT && state_q == S_WDATA
		&& !wp_q && !buf_full && !prog_busy && !start_det && !stop_det;

	// ----------------------------------------
	// Programming launch
	// ----------------------------------------

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			prog_start_q <= 1'b0;
		else
			prog_start_q <= stop_det && after_ack_q && wr_pending_q && !prog_busy;
	end

	// ----------------------------------------
	// Write word buffer
	// ----------------------------------------

	assign buf_full = wr_ptr_q == {!rd_ptr_q[PTR_W], rd_ptr_q[PTR_W-1:0]};
	assign buf_empty = wr_ptr_q == rd_ptr_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (wr_ready && !buf_empty)
				rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (push)
			buf_q[wr_ptr_q[PTR_W-1:0]] <= '{addr: addr_q, data: shift_q};
	end

	assign wr_valid = !buf_empty;
	assign wr_word = buf_q[rd_ptr_q[PTR_W-1:0]];
	assign mem_addr = addr_q;
	assign prog_start = prog_start_q;
	assign sda_out = 1'b0;
	assign sda_oe_n = !drive_low_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	a_busy_release:
	assert property (@(posedge clock) disable iff (rst)
		prog_busy |=> sda_oe_n && state_q == S_IDLE)
		else $error("Data line held during programming");

	a_start_abort:
	assert property (@(posedge clock) disable iff (rst)
		start_det |=> state_q == S_SELECT && bit_cnt_q == CNT_RESET && sda_oe_n)
		else $error("Start did not restart the select byte");

	a_stop_idle:
	assert property (@(posedge clock) disable iff (rst)
		stop_det |=> state_q == S_IDLE && sda_oe_n)
		else $error("Stop did not return to standby");

	a_prog_launch:
	assert property (@(posedge clock) disable iff (rst)
		stop_det && after_ack_q && wr_pending_q && !prog_busy |=> prog_start ##1 !prog_start)
		else $error("Programming not launched as one pulse");

	a_prog_slot:
	assert property (@(posedge clock) disable iff (rst)
		prog_start |-> $past(after_ack_q) && $past(stop_det))
		else $error("Programming launched outside the ack slot");

	a_sample_rise:
	assert property (@(posedge clock) disable iff (rst)
		scl_rise && state_q != S_IDLE && bit_cnt_q < ACK_SLOT && !start_det && !prog_busy
		|=> shift_q[0] == $past(sda_s) && bit_cnt_q == $past(bit_cnt_q) + 4'h1)
		else $error("Bit not sampled on rising clock");

	a_inhibit_nack:
	assert property (@(posedge clock) disable iff (rst)
		scl_fall && !ninth_q && bit_cnt_q == ACK_SLOT && state_q == S_WDATA && wp_q
		&& !start_det && !stop_det |-> !push ##1 sda_oe_n)
		else $error("Data byte acknowledged under inhibit");

	a_select_miss:
	assert property (@(posedge clock) disable iff (rst)
		scl_fall && !ninth_q && bit_cnt_q == ACK_SLOT && state_q == S_SELECT
		&& !prog_busy && !start_det && !stop_det
		&& !sel_match(shift_q, pin_s_q[PIN_STRAP_HI], pin_s_q[PIN_STRAP_LO])
		|=> state_q == S_IDLE && sda_oe_n)
		else $error("Foreign select byte answered");

	a_ack_release:
	assert property (@(posedge clock) disable iff (rst)
		scl_fall && ninth_q && state_q != S_RDATA |=> sda_oe_n)
		else $error("Acknowledge not released on falling clock");

	a_read_nack:
	assert property (@(posedge clock) disable iff (rst)
		scl_rise && bit_cnt_q == ACK_SLOT && state_q == S_RDATA && sda_s
		&& !start_det && !stop_det && !prog_busy |=> state_q == S_IDLE [*2])
		else $error("Read continued after master refusal");

endmodule

//--- logic/seif_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM bus slave front end
// Assumes: Bus pins are sampled by a 10 MHz system clock
// Notes: Operation list below summarises the behaviour of seif_front
//
// Operation
// - Data falling while clock high marks a start and begins a transfer.
// - Starts are watched always except during programming; idle until a start.
// - Data rising while clock high marks a stop and ends communication.
// - Master no-acknowledge on a read byte, then stop, leaves device in standby.
// - A stop closing a write command launches the programming cycle.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Received data is sampled on each rising clock edge.
// - Select byte MSB first: type id, strap two, strap one, top address, direction.
// - Respond only when type id matches and chip bits equal strap inputs.
// - An unconnected strap input reads as low.
// - Select bit zero set means read, clear means write.
// - Matching select is acknowledged in ninth slot; mismatch returns to standby.
// - Write inhibit high blocks every modification of the memory; seif_front samples it only from start to the end of the address bytes.
// - An unconnected write inhibit input reads low and permits writes.
// - Under write inhibit, select and address acknowledged, data bytes refused.
// - Data output only pulls low or releases, never drives high.
// - Device is slave only, clocked by master, never starting a transfer.
// - Device comes up in standby after reset and ignores everything before.
// - Reset reasserted at power-down stops all responses at once.
// - Sequential reads of one or more bytes, regardless of write inhibit.
// - Seventeen-bit address: top bit from select, then high, then low byte.
// - Programming starts only for a stop in the slot right after acknowledge.
// - During programming the data output stays released, no request answered.
// - A page write takes up to 256 bytes within one row.

package seif_pkg;

	localparam int ADDR_W = 17;
	localparam int BYTE_W = 8;
	localparam int PAGE_BITS = 8;
	localparam int SEL_ID_MSB = 7;
	localparam int SEL_ID_LSB = 4;
	localparam int SEL_STRAP_HI = 3;
	localparam int SEL_STRAP_LO = 2;
	localparam int SEL_TOP_ADDR = 1;
	localparam int SEL_RW = 0;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam int PIN_COUNT = 5;
	localparam int PIN_SCL = 4;
	localparam int PIN_SDA = 3;
	localparam int PIN_STRAP_HI = 2;
	localparam int PIN_STRAP_LO = 1;
	localparam int PIN_WINHIBIT = 0;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h18;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h0_0000;

	typedef enum logic [2:0] {
		S_IDLE,
		S_SELECT,
		S_ADDR_HI,
		S_ADDR_LO,
		S_WDATA,
		S_RDATA
	} seif_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] data;
	} seif_wr_word_t;

endpackage

//--- sim/seif_bus_master.sv
// Purpose: Bus master model for the two-wire link of the front end
// Assumes: Clock line pulled up between frames; data line wired-AND with pull-up
// Notes: One bit is eight system clocks, four low then four high
`timescale 1ns/10ps

module seif_bus_master (
	input wire logic clock,
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	// ----------------
	// Bit timing
	// ----------------
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic q();
		repeat (2) @(posedge clock);
	endtask

	task automatic start_cond();
		q();
		sda_low <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		q();
		sda_low <= 1'b1;
		q();
		q();
		scl <= 1'b0;
	endtask

	task automatic stop_cond();
		q();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		q();
		sda_low <= 1'b0;
		q();
		q();
	endtask

	// Data changes only with the clock low
	task automatic put_bit(input logic b, output logic seen);
		q();
		sda_low <= ~b;
		q();
		scl <= 1'b1;
		q();
		q();
		seen = sda_line;
		scl <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack, output logic bad);
		logic s;
		bad = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(b[i], s);
			bad = bad | (s !== b[i]);
		end
		put_bit(1'b1, ack);
	endtask

	// Last byte is answered with no acknowledge
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(1'b1, b[i]);
		put_bit(last, s);
	endtask
endmodule

//--- sim/tb.sv
// Purpose: Self-checking bench for the bus slave front end
// Assumes: Memory model returns address low byte xor a5
// Notes: Wire level is resolved here from both open-drain drivers
`timescale 1ns/10ps

module tb;
	import seif_pkg::*;
	localparam logic [3:0] ID = 4'h5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic scl, m_low, sda_line, sda_out, sda_oe_n, wr_valid, prog_start, a, bad;
	logic strap_lo = 1'b0;
	logic strap_hi = 1'b1;
	logic inhibit = 1'b0;
	logic wr_ready = 1'b1;
	logic prog_busy = 1'b0;
	logic [ADDR_W-1:0] mem_addr;
	logic [BYTE_W-1:0] mem_rd_data;
	logic [7:0] rb;
	seif_wr_word_t wr_word;
	seif_wr_word_t words[$];
	int n_errors = 0;
	int cmp_count = 0;
	int n_prog = 0;

	always #50 clock = ~clock;
	assign sda_line = (m_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
	assign mem_rd_data = mem_addr[7:0] ^ 8'ha5;

	always @(posedge clock)
	begin
		if (wr_valid && wr_ready)
			words.push_back(wr_word);
		if (prog_start)
			n_prog++;
	end

	seif_bus_master M (.clock(clock), .scl(scl), .sda_low(m_low), .sda_line(sda_line));

	seif_front #(.TYPE_ID(ID), .BUF_DEPTH(2)) DUT (.clock(clock), .rst(rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.select_strap_low_bit(strap_lo), .select_strap_high_bit(strap_hi),
		.write_inhibit_in(inhibit), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
		.prog_start(prog_start), .prog_busy(prog_busy));

	// ----------------
	// Shared tasks
	// ----------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [7:0] sel(int hi, int lo, int top, int rd);
		return {ID, 1'(hi), 1'(lo), 1'(top), 1'(rd)};
	endfunction

	task automatic sb(input logic [7:0] b, input int exp, input string name);
		M.send_byte(b, a, bad);
		check(name, a, exp);
		check("bus echo", bad, 0);
	endtask

	// ----------------
	// Tests
	// ----------------
	initial
	begin
		#2000000;
		n_errors++;
		$display("Watchdog expired");
		end_sim();
	end

	initial
	begin
		repeat (20) @(posedge clock);
		check("oe_n in reset", sda_oe_n, 1);
		check("addr in reset", mem_addr, 0);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		M.start_cond();
		sb(sel(1, 0, 1, 0), 0, "sel");
		sb(8'h12, 0, "addr hi");
		sb(8'hff, 0, "addr lo");
		sb(8'h3c, 0, "data 0");
		sb(8'hc3, 0, "data 1");
		M.stop_cond();
		repeat (4) @(posedge clock);
		check("prog count", n_prog, 1);
		check("word count", words.size(), 2);
		check("word 0", words[0], {17'h1_12ff, 8'h3c});
		check("word 1", words[1], {17'h1_1200, 8'hc3});
		words = {};
		$display("Test page write done");
		for (int i = 0; i < 5; i++)
		begin
			M.start_cond();
			sb(i < 4 ? sel(i / 2, i % 2, 0, 0) : {ID ^ 4'h3, 4'h8}, int'(i != 2),
				"sel match");
		end
		strap_hi <= 1'b0;
		strap_lo <= 1'b1;
		M.start_cond();
		sb(sel(0, 1, 0, 0), 0, "swapped straps");
		M.start_cond();
		sb(sel(1, 0, 0, 0), 1, "old straps");
		strap_hi <= 1'b1;
		strap_lo <= 1'b0;
		M.start_cond();
		sb(sel(1, 0, 0, 0), 0, "sel");
		sb(8'h00, 0, "addr hi");
		sb(8'h20, 0, "addr lo");
		sb(8'h5a, 0, "data");
		for (int i = 0; i < 3; i++)
			M.put_bit(1'b0, a);
		M.stop_cond();
		repeat (4) @(posedge clock);
		check("prog count", n_prog, 1);
		check("stray word count", words.size(), 1);
		check("stray word", words[0], {17'h0_0020, 8'h5a});
		words = {};
		$display("Test select and stray stop done");
		@(posedge clock);
		inhibit <= 1'b1;
		M.start_cond();
		sb(sel(1, 0, 0, 0), 0, "sel");
		sb(8'h00, 0, "addr hi");
		sb(8'h10, 0, "addr lo");
		sb(8'h77, 1, "inhibited data");
		M.start_cond();
		sb(sel(1, 0, 0, 0), 0, "sel");
		sb(8'h00, 0, "addr hi");
		for (int i = 0; i < 4; i++)
			M.put_bit(1'b1, a);
		M.start_cond();
		sb(sel(1, 0, 0, 0), 0, "fresh sel");
		sb(8'h00, 0, "addr hi");
		sb(8'h10, 0, "addr lo");
		M.start_cond();
		sb(sel(1, 0, 0, 1), 0, "read sel");
		M.get_byte(1'b0, rb);
		check("read 0", rb, 8'hb5);
		M.get_byte(1'b1, rb);
		check("read 1", rb, 8'hb4);
		M.stop_cond();
		repeat (4) @(posedge clock);
		check("no words", words.size(), 0);
		check("prog count", n_prog, 1);
		$display("Test inhibit and read done");
		inhibit <= 1'b0;
		wr_ready <= 1'b0;
		M.start_cond();
		sb(sel(1, 0, 0, 0), 0, "sel");
		sb(8'h00, 0, "addr hi");
		sb(8'h00, 0, "addr lo");
		sb(8'h11, 0, "data 0");
		sb(8'h22, 0, "data 1");
		sb(8'h33, 1, "full data");
		M.stop_cond();
		repeat (4) @(posedge clock);
		check("prog count", n_prog, 2);
		check("valid stalled", wr_valid, 1);
		wr_ready <= 1'b1;
		repeat (4) @(posedge clock);
		check("word count", words.size(), 2);
		check("word 0", words[0], {17'h0_0000, 8'h11});
		check("word 1", words[1], {17'h0_0001, 8'h22});
		check("drained", wr_valid, 0);
		$display("Test buffer stall done");
		prog_busy <= 1'b1;
		M.start_cond();
		sb(sel(1, 0, 0, 1), 1, "busy sel");
		M.stop_cond();
		prog_busy <= 1'b0;
		repeat (4) @(posedge clock);
		check("busy prog", n_prog, 2);
		rb = sel(1, 0, 0, 0);
		M.start_cond();
		for (int i = 7; i >= 0; i--)
			M.put_bit(rb[i], a);
		repeat (6) @(posedge clock);
		check("ack drive", sda_oe_n, 0);
		check("drive low", sda_out, 0);
		rst <= 1'b1;
		@(negedge clock);
		check("oe_n after reset", sda_oe_n, 1);
		@(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		M.put_bit(1'b1, a);
		check("ignored after reset", a, 1);
		M.stop_cond();
		$display("Test reset done");
		end_sim();
	end
endmodule
